// ===== shared/cmrc_pkg.sv
// Constants and types shared by the clock mode and reset control block
package cmrc_pkg;

	// APB address width and register word indices
	localparam int unsigned ADDR_W = 12;
	localparam logic [7:0] MODE_IDX = 8'hCA;
	localparam logic [7:0] STAT_IDX = 8'hCB;
	localparam logic [ADDR_W-1:0] MODE_ADDR = {2'h0, MODE_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

	// Oscillator mode register layout
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] MODE_WMASK = 8'h1E;
	localparam int unsigned STOP_BIT = 1;
	localparam int unsigned SLOW_BIT = 2;
	localparam int unsigned MODE_LO = 3;
	localparam int unsigned MODE_HI = 4;

	// Status register layout
	localparam int unsigned ST_SLOW_BIT = 0;
	localparam int unsigned ST_RESET_BIT = 1;
	localparam int unsigned ST_RUN_BIT = 2;

	// Instruction clock dividers and program origin
	localparam logic [2:0] SLOW_DIV_LAST = 3'h3;
	localparam logic [11:0] PROG_ORIGIN = 12'h000;

	// Oscillator warm-up lengths in oscillator cycles
	localparam logic [11:0] WARM_XTAL_CYC = 12'h400;
	localparam logic [11:0] WARM_RC_CYC = 12'h020;

	// CPU mode field encoding
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_SLEEP  = 2'h1,
		MODE_GREEN  = 2'h2,
		MODE_RSVD   = 2'h3
	} cmrc_mode_t;

	// High clock source option
	typedef enum logic [2:0] {
		HC_IRC      = 3'h0,
		HC_IRC_RTC  = 3'h1,
		HC_EXT_RC   = 3'h2,
		HC_XTAL_32K = 3'h3,
		HC_XTAL_4M  = 3'h4,
		HC_XTAL_8M  = 3'h5
	} cmrc_hclk_t;

	// Reset sequence states
	typedef enum logic [1:0] {SEQ_PIN_WAIT, SEQ_INIT, SEQ_WARM, SEQ_RUN} cmrc_seq_t;

endpackage

// ===== shared/cmrc_clk_if.sv
// Clock selection and divider signals between control and divider
`timescale 1ns/1ns
interface cmrc_clk_if;
	logic       slow_req;
	logic [2:0] div_last;
	logic       run;
	logic       hclk_tick;
	logic       losc_tick;
	logic       cur_slow;
	logic       cpu_tick;

	modport ctl (output slow_req, output div_last, output run, output hclk_tick,
		output losc_tick, input cur_slow, input cpu_tick);
	modport div (input slow_req, input div_last, input run, input hclk_tick,
		input losc_tick, output cur_slow, output cpu_tick);
endinterface

// ===== rtl/cmrc_clk_div.sv
// Glitch-free system clock switch and instruction clock divider
`timescale 1ns/1ns
module cmrc_clk_div
	import cmrc_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_nrst,
	cmrc_clk_if.div   bus
);
	logic [2:0] cnt;
	logic       src_tick;
	logic [2:0] last;
	logic       switch_ok;

	// Current source and its divide ratio
	assign src_tick = bus.cur_slow ? bus.losc_tick : bus.hclk_tick;
	assign last = bus.cur_slow ? SLOW_DIV_LAST : bus.div_last; // [RULE7] [RULE8]
	// Switch only where a period ends or while run is low, so no short cycle reaches the divider
	assign switch_ok = !bus.run || (src_tick ? (cnt == last) : (cnt == 3'h0));

	////////////////////////////////////////////////////////////////////////////
	// Divider counter and instruction tick
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt <= 3'h0;
			bus.cpu_tick <= 1'b0;
		end
		else
		begin
			bus.cpu_tick <= bus.run && src_tick && (cnt == last); // [RULE7] [RULE8]
			if (!bus.run)
				cnt <= 3'h0;
			else if (src_tick)
				cnt <= (cnt == last) ? 3'h0 : cnt + 3'h1;
		end
	end

	// Source selection follows the request only at a boundary or while run is low
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			bus.cur_slow <= 1'b0;
		else if (switch_ok)
			bus.cur_slow <= bus.slow_req; // [RULE6] [RULE17]
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	a_div_high_wrap: assert property ( // [RULE7]
		bus.run && !bus.cur_slow && bus.hclk_tick && cnt == bus.div_last |=> bus.cpu_tick)
		else $error("high clock divider did not wrap at N");
	a_div_slow_four: assert property ( // [RULE8]
		bus.cpu_tick && $past(bus.cur_slow) |-> $past(cnt) == 3'h3)
		else $error("slow instruction tick not every fourth low clock");
	a_switch_clean: assert property ( // [RULE17]
		bus.cur_slow != $past(bus.cur_slow) |-> cnt == 3'h0)
		else $error("clock source switched mid period");
	c_to_slow: cover property ($rose(bus.cur_slow));
endmodule

// ===== rtl/cmrc_rst_seq.sv
// External reset pin, initialisation and warm-up sequencer
`timescale 1ns/1ns
module cmrc_rst_seq
	import cmrc_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_pin_en,
	input  wire logic i_pin_n,
	input  wire logic i_osc_tick,
	input  wire logic i_xtal,
	output logic      o_sys_init,
	output logic      o_running,
	output logic      o_fetch_start
);
	cmrc_seq_t   state;
	logic [11:0] warm_cnt;
	logic [11:0] warm_last;
	logic        pin_hold;

	assign pin_hold = i_pin_en && !i_pin_n; // [RULE1]
	assign warm_last = (i_xtal ? WARM_XTAL_CYC : WARM_RC_CYC) - 12'h1; // [RULE16]
	assign o_sys_init = (state == SEQ_INIT);
	assign o_running = (state == SEQ_RUN);

	////////////////////////////////////////////////////////////////////////////
	// Sequence state, pin low wins from any state
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			state <= SEQ_PIN_WAIT;
		else if (pin_hold)
			state <= SEQ_PIN_WAIT; // [RULE2] [RULE3]
		else
		begin
			unique case (state)
				SEQ_PIN_WAIT: state <= SEQ_INIT; // [RULE3]
				SEQ_INIT:     state <= SEQ_WARM; // [RULE4]
				SEQ_WARM:     if (i_osc_tick && warm_cnt == warm_last) state <= SEQ_RUN;
				SEQ_RUN:      state <= SEQ_RUN;
			endcase
		end
	end

	// Warm-up counter and fetch start pulse
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			warm_cnt <= 12'h0;
			o_fetch_start <= 1'b0;
		end
		else
		begin
			o_fetch_start <= !pin_hold && state == SEQ_WARM && i_osc_tick
				&& warm_cnt == warm_last; // [RULE5]
			if (state != SEQ_WARM)
				warm_cnt <= 12'h0;
			else if (i_osc_tick)
				warm_cnt <= warm_cnt + 12'h1; // [RULE16]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	a_warm_full_len: assert property ( // [RULE16]
		o_fetch_start |-> $past(warm_cnt) == $past(warm_last) && $past(state) == SEQ_WARM)
		else $error("warm-up ended before its count");
	a_init_then_warm: assert property ( // [RULE4]
		state == SEQ_INIT && !pin_hold |=> state == SEQ_WARM && warm_cnt == 12'h0)
		else $error("initialisation not followed by warm-up");
	c_warm_done: cover property (o_fetch_start);
endmodule

// ===== rtl/cmrc_top.sv
// Clock mode register, oscillator enables and reset sequence top level
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns

// Operation
// RULE1 - Reset pin active low when option enabled
// RULE2 - Pin honoured at power-up and running
// RULE3 - Stay in reset while pin low
// RULE4 - Load initial register values before warm-up
// RULE5 - After warm-up, fetch from address zero
// RULE6 - System clock from high or low source
// RULE7 - Normal mode: high clock divided by N
// RULE8 - Slow mode: low clock divided by four
// RULE9 - Mode register, bits four to one
// RULE10 - Stop bit halts high oscillator only
// RULE11 - Clock-mode bit selects high or low
// RULE12 - Mode field: normal, sleep, green, reserved
// RULE13 - Stop bit halts option's chosen high sources
// RULE14 - Sleep stops high and low oscillators
// RULE15 - Low oscillator stopped only by mode field
// RULE16 - Warm-up longer for crystal than RC
// RULE17 - Glitch-free switch between clock sources
module cmrc_top
	import cmrc_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic [3:0]        i_pstrb,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic              i_rst_pin_n,
	input  wire logic              i_rst_pin_en,
	input  wire cmrc_hclk_t        i_high_clk_opt,
	input  wire logic [2:0]        i_fcpu_div,
	input  wire logic              i_hclk_tick,
	input  wire logic              i_losc_tick,
	output logic                   o_irc_en,
	output logic                   o_ext_osc_en,
	output logic                   o_rtc_xtal_en,
	output logic                   o_losc_en,
	output logic                   o_clk_low,
	output logic                   o_cpu_tick,
	output logic                   o_cpu_run,
	output logic                   o_sleep,
	output logic                   o_green,
	output logic                   o_in_reset,
	output logic                   o_fetch_start,
	output logic [11:0]            o_fetch_addr
);
	cmrc_clk_if clk_bus ();

	logic [7:0] mode_reg;
	cmrc_mode_t mode;
	logic       high_osc_stop;
	logic       clock_mode_select;
	logic       hclk_on;
	logic       internal_src;
	logic       xtal_src;
	logic       sys_init;
	logic       running;
	logic       fetch_start;
	logic       hit_mode;
	logic       hit_stat;
	logic       setup;
	logic       access;
	logic       wr_mode;
	logic [7:0] stat;
	logic [7:0] next_rdata;

	////////////////////////////////////////////////////////////////////////////
	// Register field decode
	assign high_osc_stop = mode_reg[STOP_BIT];
	assign clock_mode_select = mode_reg[SLOW_BIT];
	assign mode = cmrc_mode_t'(mode_reg[MODE_HI:MODE_LO]); // [RULE12]

	// High clock option classes
	assign internal_src = (i_high_clk_opt == HC_IRC) || (i_high_clk_opt == HC_IRC_RTC);
	assign xtal_src = (i_high_clk_opt == HC_XTAL_32K) || (i_high_clk_opt == HC_XTAL_4M)
		|| (i_high_clk_opt == HC_XTAL_8M) || (i_high_clk_opt == HC_IRC_RTC);

	// High oscillator runs unless stopped or asleep
	assign hclk_on = !high_osc_stop && (mode != MODE_SLEEP); // [RULE10] [RULE14]

	////////////////////////////////////////////////////////////////////////////
	// APB decode; the slave answers with no wait state
	assign setup = i_psel && !i_penable;
	assign access = i_psel && i_penable;
	assign hit_mode = (i_paddr == MODE_ADDR);
	assign hit_stat = (i_paddr == STAT_ADDR);
	assign o_pready = 1'b1;
	assign o_pslverr = access && !hit_mode && !hit_stat;
	// Writes land only while the system is out of reset
	assign wr_mode = access && i_pwrite && hit_mode && i_pstrb[0] && running;

	// Status view of the block's own state
	always_comb
	begin
		stat = 8'h00;
		stat[ST_SLOW_BIT] = clk_bus.cur_slow;
		stat[ST_RESET_BIT] = !running;
		stat[ST_RUN_BIT] = o_cpu_run;
	end

	// Read mux; reserved bits are zero through the write mask
	always_comb
	begin
		next_rdata = 8'h00;
		if (hit_mode)
			next_rdata = mode_reg; // [RULE9]
		else if (hit_stat)
			next_rdata = stat;
	end

	// Read data is captured in the setup cycle and held for the access cycle
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_prdata <= 32'h0000_0000;
		else if (setup)
			o_prdata <= {24'h00_0000, next_rdata};
	end

	////////////////////////////////////////////////////////////////////////////
	// Oscillator mode register; held at its initial value until running
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			mode_reg <= MODE_RST;
		else if (sys_init || !running)
			mode_reg <= MODE_RST; // [RULE4]
		else if (wr_mode)
			mode_reg <= i_pwdata[7:0] & MODE_WMASK; // [RULE9]
	end

	////////////////////////////////////////////////////////////////////////////
	// Oscillator enables per high clock option and CPU mode
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_irc_en <= 1'b1;
			o_ext_osc_en <= 1'b1;
			o_rtc_xtal_en <= 1'b1;
			o_losc_en <= 1'b1;
		end
		else
		begin
			o_irc_en <= hclk_on && internal_src; // [RULE13]
			o_ext_osc_en <= hclk_on && !internal_src; // [RULE13]
			o_rtc_xtal_en <= hclk_on && (i_high_clk_opt == HC_IRC_RTC); // [RULE13]
			o_losc_en <= (mode != MODE_SLEEP); // [RULE14] [RULE15]
		end
	end

	// CPU mode outputs; green and sleep halt instruction execution
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_cpu_run <= 1'b0;
			o_sleep <= 1'b0;
			o_green <= 1'b0;
		end
		else
		begin
			o_cpu_run <= running && (mode != MODE_SLEEP) && (mode != MODE_GREEN); // [RULE12]
			o_sleep <= running && (mode == MODE_SLEEP); // [RULE12]
			o_green <= running && (mode == MODE_GREEN); // [RULE12]
		end
	end

	// Program counter start address on the end of the power-on sequence
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_fetch_addr <= PROG_ORIGIN;
		else if (fetch_start)
			o_fetch_addr <= PROG_ORIGIN; // [RULE5]
	end

	assign o_fetch_start = fetch_start;
	assign o_in_reset = !running;

	////////////////////////////////////////////////////////////////////////////
	// Clock switch and divider hookup; ticks only count while the source runs
	assign clk_bus.slow_req = clock_mode_select; // [RULE11]
	assign clk_bus.div_last = i_fcpu_div;
	assign clk_bus.run = o_cpu_run;
	assign clk_bus.hclk_tick = i_hclk_tick && (o_irc_en || o_ext_osc_en);
	assign clk_bus.losc_tick = i_losc_tick && o_losc_en;
	assign o_clk_low = clk_bus.cur_slow; // [RULE6]
	assign o_cpu_tick = clk_bus.cpu_tick;

	cmrc_clk_div u_div (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.bus    (clk_bus.div)
	);

	// Reset sequencer warms up on the high source after initialisation
	cmrc_rst_seq u_seq (
		.i_clk         (i_clk),
		.i_nrst        (i_nrst),
		.i_pin_en      (i_rst_pin_en),
		.i_pin_n       (i_rst_pin_n),
		.i_osc_tick    (clk_bus.hclk_tick),
		.i_xtal        (xtal_src),
		.o_sys_init    (sys_init),
		.o_running     (running),
		.o_fetch_start (fetch_start)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	a_pin_low_reset: assert property ( // [RULE1]
		i_rst_pin_en && !i_rst_pin_n |=> o_in_reset ##1 !o_cpu_run)
		else $error("low reset pin did not hold reset");
	a_pin_hold_wait: assert property ( // [RULE3]
		(i_rst_pin_en && !i_rst_pin_n)[*3] |=> o_in_reset && !o_fetch_start)
		else $error("left reset while pin stayed low");
	a_start_pin_high: assert property ( // [RULE2]
		$fell(o_in_reset) |-> $past(!i_rst_pin_en || i_rst_pin_n))
		else $error("left reset with pin low");
	a_init_clears: assert property ( // [RULE4]
		sys_init |=> mode_reg == MODE_RST)
		else $error("initialisation left the mode register set");
	a_fetch_origin: assert property ( // [RULE5]
		fetch_start |=> o_fetch_addr == PROG_ORIGIN && !o_in_reset)
		else $error("fetch did not begin at origin");
	a_reg_reserved: assert property ( // [RULE9]
		access && hit_mode && !i_pwrite |-> o_prdata[7:5] == 3'h0 && o_prdata[0] == 1'b0)
		else $error("reserved mode register bits read nonzero");
	a_stop_high_clk: assert property ( // [RULE10]
		high_osc_stop && !sys_init |=> !o_irc_en && !o_ext_osc_en && !o_rtc_xtal_en)
		else $error("stop bit left a high source running");
	a_slow_follows: assert property ( // [RULE11]
		$rose(clk_bus.cur_slow) |-> $past(clock_mode_select))
		else $error("low clock chosen without clock-mode bit");
	a_green_halt: assert property ( // [RULE12]
		running && mode == MODE_GREEN |=> !o_cpu_run && o_green)
		else $error("green mode did not halt the CPU");
	a_rtc_stop: assert property ( // [RULE13]
		!hclk_on && i_high_clk_opt == HC_IRC_RTC |=> !o_rtc_xtal_en && !o_irc_en)
		else $error("stop bit left RTC crystal running");
	a_sleep_stops: assert property ( // [RULE14]
		mode == MODE_SLEEP |=> !o_losc_en && !o_irc_en && !o_ext_osc_en)
		else $error("sleep left an oscillator running");
	a_losc_only_mode: assert property ( // [RULE15]
		mode != MODE_SLEEP |=> o_losc_en)
		else $error("low oscillator stopped outside sleep");

	c_write_slow: cover property (wr_mode && i_pwdata[SLOW_BIT]);
	c_sleep: cover property ($rose(o_sleep));
	c_pin_while_run: cover property (running && i_rst_pin_en && !i_rst_pin_n);
endmodule

// ===== testbench/cmrc_osc_model.sv
// Oscillator model: high and low clock ticks gated by their enables
`timescale 1ns/1ns
module cmrc_osc_model
#(
	parameter int LPER = 3
)
(
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_high_en,
	input  wire logic i_low_en,
	output logic      o_hclk_tick,
	output logic      o_losc_tick
);
	int lcnt;

	////////////////////////////////////////////////////////////////////////////////
	// High source ticks every cycle, low RC every LPER cycles, none when stopped
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			lcnt <= 0;
			o_hclk_tick <= 1'h0;
			o_losc_tick <= 1'h0;
		end
		else
		begin
			o_hclk_tick <= i_high_en;
			lcnt <= (lcnt == LPER - 1) ? 0 : lcnt + 1;
			o_losc_tick <= i_low_en && (lcnt == LPER - 1);
		end
	end
endmodule

// ===== testbench/tb.sv
// Self-checking testbench for the clock mode and reset control block
`timescale 1ns/1ns
module tb
	import cmrc_pkg::*;
;
	localparam int LPER = 3;
	logic              clk, nrst, psel, pen, pwr, pin_n, pin_en;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic [2:0]        div;
	cmrc_hclk_t        opt;
	logic              pready, pslverr, hclk, losc, irc_en, ext_en, rtc_en, losc_en;
	logic              clk_low, cpu_tick, cpu_run, sleep, green, in_rst, fstart;
	logic [11:0]       faddr;
	int                err_total, compares;

	cmrc_top u_dut (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rst_pin_n(pin_n),
		.i_rst_pin_en(pin_en), .i_high_clk_opt(opt), .i_fcpu_div(div), .i_hclk_tick(hclk),
		.i_losc_tick(losc), .o_irc_en(irc_en), .o_ext_osc_en(ext_en),
		.o_rtc_xtal_en(rtc_en), .o_losc_en(losc_en), .o_clk_low(clk_low),
		.o_cpu_tick(cpu_tick), .o_cpu_run(cpu_run), .o_sleep(sleep), .o_green(green),
		.o_in_reset(in_rst), .o_fetch_start(fstart), .o_fetch_addr(faddr));

	cmrc_osc_model #(.LPER(LPER)) u_osc (.i_clk(clk), .i_nrst(nrst),
		.i_high_en(irc_en | ext_en), .i_low_en(losc_en), .o_hclk_tick(hclk),
		.o_losc_tick(losc));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		#300000;
		err_total++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask

	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, a, d, r, e);
	endtask

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] r;
		logic        e;
		apb(1'h0, a, 32'h0, r, e);
		chk(r, exp);
		chk(e, ee);
	endtask

	task automatic wait_fetch(output int n);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (fstart !== 1'h1);
	endtask

	// Skips one partial and one full period, then counts cycles between instruction ticks
	task automatic period(input int exp);
		int n;
		repeat (2)
			do
				@(negedge clk);
			while (cpu_tick !== 1'h1);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (cpu_tick !== 1'h1);
		chk(n, exp);
	endtask

	task automatic boot(input cmrc_hclk_t o, input logic [2:0] d);
		int   n;
		int   w;
		@(posedge clk);
		nrst <= 1'h0;
		opt <= o;
		div <= d;
		pin_en <= 1'h0;
		pin_n <= 1'h1;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		wait_fetch(n);
		w = (o == HC_IRC || o == HC_EXT_RC) ? WARM_RC_CYC : WARM_XTAL_CYC;
		chk(n >= w && n <= w + 8, 1'h1);
		chk(faddr, PROG_ORIGIN);
		chk(in_rst, 1'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		boot(HC_IRC, 3'h0);
		rchk(MODE_ADDR, 32'h0, 1'h0);
		rchk(STAT_ADDR, 32'h4, 1'h0);
		rchk(12'h000, 32'h0, 1'h1);
		wreg(MODE_ADDR, 32'hFFFFFFE1);
		rchk(MODE_ADDR, 32'h0, 1'h0);
		wreg(MODE_ADDR, 32'hFFFFFFFF);
		rchk(MODE_ADDR, 32'h1E, 1'h0);
	endtask

	task automatic t_div();
		for (int d = 0; d < 8; d++)
		begin
			boot(HC_IRC, d[2:0]);
			period(d + 1);
		end
	endtask

	task automatic t_slow();
		boot(HC_IRC, 3'h1);
		wreg(MODE_ADDR, 32'h04);
		do
			@(negedge clk);
		while (clk_low !== 1'h1);
		period(4 * LPER);
		rchk(STAT_ADDR, 32'h5, 1'h0);
		wreg(MODE_ADDR, 32'h06);
		repeat (3) @(negedge clk);
		chk({irc_en, ext_en, losc_en}, 3'h1);
		period(4 * LPER);
		wreg(MODE_ADDR, 32'h00);
		do
			@(negedge clk);
		while (clk_low !== 1'h0);
		period(2);
	endtask

	task automatic t_modes();
		logic [7:0] m[4] = '{8'h08, 8'h10, 8'h18, 8'h00};
		logic [3:0] e[4] = '{4'h4, 4'h3, 4'h9, 4'h9};
		boot(HC_IRC, 3'h0);
		for (int i = 0; i < 4; i++)
		begin
			wreg(MODE_ADDR, {24'h0, m[i]});
			repeat (3) @(negedge clk);
			chk({cpu_run, sleep, green, losc_en}, e[i]);
		end
		wreg(MODE_ADDR, 32'h08);
		repeat (3) @(negedge clk);
		chk({irc_en, ext_en, rtc_en}, 3'h0);
	endtask

	task automatic t_opts();
		cmrc_hclk_t o[4] = '{HC_IRC, HC_IRC_RTC, HC_EXT_RC, HC_XTAL_4M};
		logic [1:0] e[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
		for (int i = 0; i < 4; i++)
		begin
			boot(o[i], 3'h0);
			chk({ext_en, rtc_en}, e[i]);
			wreg(MODE_ADDR, 32'h02);
			repeat (3) @(negedge clk);
			chk({irc_en, ext_en, rtc_en, losc_en}, 4'h1);
		end
	endtask

	task automatic t_pin();
		int n;
		@(posedge clk);
		nrst <= 1'h0;
		pin_en <= 1'h1;
		pin_n <= 1'h0;
		opt <= HC_IRC;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		repeat (40) @(negedge clk);
		chk({in_rst, fstart}, 2'h2);
		wreg(MODE_ADDR, 32'h04);
		rchk(MODE_ADDR, 32'h0, 1'h0);
		@(posedge clk);
		pin_n <= 1'h1;
		wait_fetch(n);
		chk(n <= WARM_RC_CYC + 8, 1'h1);
		wreg(MODE_ADDR, 32'h04);
		@(posedge clk);
		pin_n <= 1'h0;
		repeat (3) @(negedge clk);
		chk({in_rst, cpu_run}, 2'h2);
		@(posedge clk);
		pin_n <= 1'h1;
		wait_fetch(n);
		rchk(MODE_ADDR, 32'h0, 1'h0);
		@(posedge clk);
		pin_en <= 1'h0;
		pin_n <= 1'h0;
		repeat (5) @(negedge clk);
		chk(in_rst, 1'h0);
	endtask

	task automatic end_of_test();
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		err_total = 0;
		compares = 0;
		nrst = 1'h0;
		psel = 1'h0;
		pen = 1'h0;
		pwr = 1'h0;
		paddr = '0;
		pwdata = 32'h0;
		pin_n = 1'h1;
		pin_en = 1'h0;
		opt = HC_IRC;
		div = 3'h0;
		repeat (2) @(posedge clk);
		t_regs();
		t_div();
		t_slow();
		t_modes();
		t_opts();
		t_pin();
		end_of_test();
	end
endmodule
